//--- rtl/psr_map.vh
// constants, field positions and timing counts of the pressure readout block
`ifndef PSR_MAP_VH
`define PSR_MAP_VH

// ----------------------------------------------------------------
// mode control register fields and reset value
// ----------------------------------------------------------------
`define PSR_MODE_RESET 8'h93
`define PSR_MODE_RANGE_LSB 0
`define PSR_MODE_RANGE_MSB 1
`define PSR_MODE_FILT_LSB 2
`define PSR_MODE_FILT_MSB 4
`define PSR_MODE_AZ_EN 5
`define PSR_MODE_AZ_TRACK 6
`define PSR_MODE_NOISE_SUP 7

// ----------------------------------------------------------------
// rate control register reset value
// ----------------------------------------------------------------
`define PSR_RATE_RESET 8'h00

// ----------------------------------------------------------------
// extended stream layout (zero-based byte index)
// ----------------------------------------------------------------
`define PSR_IDX_PRESS_HI 5'h00
`define PSR_IDX_PRESS_LO 5'h01
`define PSR_IDX_TEMP_HI 5'h02
`define PSR_IDX_TEMP_LO 5'h03
`define PSR_IDX_MODEL_0 5'h04
`define PSR_IDX_SERIAL_0 5'h0A
`define PSR_IDX_BUILD_0 5'h0E
`define PSR_STREAM_LEN 5'h14
`define PSR_UNDEF_BYTE 8'h00

// ----------------------------------------------------------------
// output scaling: full scale lands on 90 percent of the signed span
// ----------------------------------------------------------------
`define PSR_SCALE_NUM 16'h7333
`define PSR_SCALE_SHIFT 15
`define PSR_NOISE_FLOOR 16'h0010

// ----------------------------------------------------------------
// automatic rate divisors, one per filter corner code
// ----------------------------------------------------------------
`define PSR_AUTO_DIV_0 8'h0A
`define PSR_AUTO_DIV_1 8'h05
`define PSR_AUTO_DIV_2 8'h04
`define PSR_AUTO_DIV_3 8'h03
`define PSR_AUTO_DIV_4 8'h02
`define PSR_AUTO_DIV_5 8'h02
`define PSR_AUTO_DIV_6 8'h01
`define PSR_AUTO_DIV_7 8'h01

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PSR_CLK_PERIOD_NS 100
`define PSR_POR_DELAY_NS 10000
`define PSR_POR_CYCLES ((`PSR_POR_DELAY_NS + `PSR_CLK_PERIOD_NS - 1) / `PSR_CLK_PERIOD_NS)

`endif

//--- rtl/psr_spi_slave.v
// serial shifter for the four-wire link, byte framed, msb first
`include "psr_map.vh"

module psr_spi_slave (
  input wire clk_sys,
  input wire rst_b,
  input wire linkEnable,
  input wire selActive,
  input wire sclkPin,
  input wire mosiPin,
  input wire [7:0] txByte,
  output wire startPulse,
  output wire endPulse,
  output reg [4:0] byteIdx_q,
  output reg rxStrobe_q,
  output reg [4:0] rxIdx_q,
  output reg [7:0] rxByte_q,
  output wire misoOut,
  output wire misoOe
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] sclkSync_q; // bit 0 is read only by bit 1
  reg [1:0] mosiSync_q; // same depth keeps data aligned with clock
  reg sclkPrev_q; // delayed clock for edge detection
  reg active_q; // framed and enabled, one cycle late
  reg [2:0] bitCnt_q; // bit position within byte
  reg [6:0] rxShift_q; // received bits so far
  reg [7:0] txShift_q; // outgoing byte, msb on the pin
  reg loadReq_q; // fetch txByte next cycle
  reg loadSkip_q; // boundary load: next fall must not shift
  reg skipFall_q; // swallow one falling edge
  wire active;
  wire sclkRise;
  wire sclkFall;

  assign active = linkEnable & selActive;
  assign sclkRise = sclkSync_q[1] & ~sclkPrev_q;
  assign sclkFall = ~sclkSync_q[1] & sclkPrev_q;
  assign startPulse = active & ~active_q;
  assign endPulse = ~active & active_q;
  assign misoOut = txShift_q[7];
  assign misoOe = active_q;

  // ----------------------------------------------------------------
  // synchronise and detect edges
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclkSync_q <= 2'b00;
      mosiSync_q <= 2'b00;
      sclkPrev_q <= 1'b0;
      active_q <= 1'b0;
    end
    else
    begin
      sclkSync_q <= {sclkSync_q[0], sclkPin};
      mosiSync_q <= {mosiSync_q[0], mosiPin};
      sclkPrev_q <= sclkSync_q[1];
      active_q <= active;
    end
  end

  // ----------------------------------------------------------------
  // receive side: sample on rising edge
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bitCnt_q <= 3'h0;
      rxShift_q <= 7'h00;
      byteIdx_q <= 5'h00;
      rxStrobe_q <= 1'b0;
      rxIdx_q <= 5'h00;
      rxByte_q <= 8'h00;
    end
    else
    begin
      rxStrobe_q <= 1'b0;
      if (startPulse)
      begin
        // new frame restarts at byte zero
        bitCnt_q <= 3'h0;
        byteIdx_q <= 5'h00;
      end
      else if (active && sclkRise)
      begin
        rxShift_q <= {rxShift_q[5:0], mosiSync_q[1]};
        bitCnt_q <= bitCnt_q + 3'h1;
        if (bitCnt_q == 3'h7)
        begin
          // whole byte: hand it up with its position
          rxByte_q <= {rxShift_q, mosiSync_q[1]};
          rxIdx_q <= byteIdx_q;
          rxStrobe_q <= 1'b1;
          // saturate past the stream end; index width stays small
          if (byteIdx_q != 5'h1F)
            byteIdx_q <= byteIdx_q + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit side: load per byte, shift on falling edge
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txShift_q <= 8'h00;
      loadReq_q <= 1'b0;
      loadSkip_q <= 1'b0;
      skipFall_q <= 1'b0;
    end
    else
    begin
      if (startPulse)
      begin
        // first byte: no falling edge precedes the first rise
        loadReq_q <= 1'b1;
        loadSkip_q <= 1'b0;
        skipFall_q <= 1'b0;
      end
      else if (active && sclkRise && bitCnt_q == 3'h7)
      begin
        loadReq_q <= 1'b1;
        loadSkip_q <= 1'b1;
      end
      else if (loadReq_q)
      begin
        // txByte follows byteIdx, settled one cycle after it moved
        txShift_q <= txByte;
        loadReq_q <= 1'b0;
        skipFall_q <= loadSkip_q;
      end
      else if (active && sclkFall)
      begin
        if (skipFall_q)
          skipFall_q <= 1'b0;
        else
          txShift_q <= {txShift_q[6:0], 1'b0};
      end
    end
  end

endmodule // psr_spi_slave

//--- rtl/psr_rate_gen.v
// data-ready pacing: down-counter on the internal update tick
`include "psr_map.vh"

module psr_rate_gen (
  input wire clk_sys,
  input wire rst_b,
  input wire updateTick,
  input wire [7:0] rateValue,
  input wire [2:0] filterSel,
  input wire pressRead,
  output reg data_ready_flag
);

  // ----------------------------------------------------------------
  // automatic divisor per filter corner, about 498 Hz / (2 * corner)
  // ----------------------------------------------------------------
  function [7:0] autoDiv;
    input [2:0] code;
    begin
      case (code)
        3'h0: autoDiv = `PSR_AUTO_DIV_0;
        3'h1: autoDiv = `PSR_AUTO_DIV_1;
        3'h2: autoDiv = `PSR_AUTO_DIV_2;
        3'h3: autoDiv = `PSR_AUTO_DIV_3;
        3'h4: autoDiv = `PSR_AUTO_DIV_4;
        3'h5: autoDiv = `PSR_AUTO_DIV_5;
        3'h6: autoDiv = `PSR_AUTO_DIV_6;
        default: autoDiv = `PSR_AUTO_DIV_7;
      endcase
    end
  endfunction

  reg [7:0] count_q; // ticks left before expiry
  wire [7:0] reload; // divisor in force

  assign reload = (rateValue == 8'h00) ? autoDiv(filterSel) : rateValue;

  // ----------------------------------------------------------------
  // counter and flag; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_q <= 8'h01;
      data_ready_flag <= 1'b0;
    end
    else
    begin
      if (updateTick)
      begin
        if (count_q <= 8'h01)
        begin
          count_q <= reload;
          data_ready_flag <= 1'b1;
        end
        else
          count_q <= count_q - 8'h01;
      end
      if (pressRead && !(updateTick && count_q <= 8'h01))
        data_ready_flag <= 1'b0;
    end
  end

endmodule // psr_rate_gen

//--- rtl/psr_readout.v
// top of the pressure readout: link, mode and rate control, output shaping, stream
//
// Overview of operation
// - extended bytes follow pressure while host clocks
// - bytes 3-4 carry 8.8 signed temperature
// - model text bytes 5-10, build 15-20
// - serial number in bytes 11 to 14
// - one select frame streams up to 20
// - frame may stop at any byte count
// - only first two received bytes are used
// - bytes past twenty are undefined
// - mode selects range and filter corner
// - bit 5 rising edge captures zero point
// - bit 5 clear removes zero offset
// - bit 6 sampled at enable edge picks mode
// - standard mode subtracts captured zero
// - tracking follows zero inside noise floor
// - bit 7 suppresses noise around zero
// - new mode visible from second cycle
// - rate value reloads data-ready down-counter
// - zero rate means automatic rate
// - pressure signed sixteen bits, high first
// - full scale maps to 90 percent span
// - pressure read clears data-ready
// - whole words, msb first both lines
// - mode then rate sent, pressure returned
// - select pin after power-on picks interface
`include "psr_map.vh"

module psr_readout #(
  parameter [47:0] MODEL_TEXT = 48'h4142_4344_4500, // arbitrary value
  parameter [31:0] SERIAL_NUM = 32'h1234_5678, // arbitrary value
  parameter [47:0] BUILD_TEXT = 48'h3031_3233_3400 // arbitrary value
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [15:0] rawPressure,
  input wire rawValid,
  input wire [15:0] tempIn,
  input wire port_select_low,
  input wire sclkPin,
  input wire mosiPin,
  output wire misoOut,
  output wire misoOe,
  output wire data_ready_flag,
  output reg [1:0] rangeSel_q,
  output reg [2:0] filterSel_q,
  output reg noiseSupEn_q,
  output reg spiMode_q,
  output reg ifaceReady_q
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clamp a 17-bit signed difference to 16 bits
  function [15:0] sat16;
    input [16:0] v;
    begin
      if (v[16] != v[15])
        sat16 = v[16] ? 16'h8000 : 16'h7FFF;
      else
        sat16 = v[15:0];
    end
  endfunction

  // magnitude of a signed word, saturating at the top
  function [15:0] mag16;
    input [15:0] v;
    begin
      if (v == 16'h8000)
        mag16 = 16'h7FFF;
      else if (v[15])
        mag16 = 16'h0000 - v;
      else
        mag16 = v;
    end
  endfunction

  // signed difference a - b, saturated
  function [15:0] subSat;
    input [15:0] a;
    input [15:0] b;
    begin
      subSat = sat16({a[15], a} - {b[15], b});
    end
  endfunction

  // ----------------------------------------------------------------
  // select pin synchroniser and interface choice
  // ----------------------------------------------------------------
  reg [1:0] selSync_q; // bit 0 read only by bit 1
  reg [15:0] porCnt_q; // power-on delay counter
  wire selActive; // frame open on the four-wire link

  assign selActive = ~selSync_q[1];

  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      selSync_q <= 2'b11;
    else
      selSync_q <= {selSync_q[0], port_select_low};
  end

  // catch the strap level once the delay has run out
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      porCnt_q <= 16'h0000;
      ifaceReady_q <= 1'b0;
      spiMode_q <= 1'b0;
    end
    else if (!ifaceReady_q)
    begin
      if (porCnt_q == `PSR_POR_CYCLES - 1)
      begin
        // high strap selects the four-wire link
        ifaceReady_q <= 1'b1;
        spiMode_q <= selSync_q[1];
      end
      else
        porCnt_q <= porCnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------
  wire startPulse; // frame opened
  wire endPulse; // frame closed
  wire [4:0] byteIdx; // byte being sent
  wire rxStrobe; // received byte valid
  wire [4:0] rxIdx; // its position in the frame
  wire [7:0] rxByte; // its value
  reg [7:0] txByte; // byte for the current position

  // word framing and bit order live in the shifter
  psr_spi_slave uLink (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .linkEnable(ifaceReady_q & spiMode_q),
    .selActive(selActive),
    .sclkPin(sclkPin),
    .mosiPin(mosiPin),
    .txByte(txByte),
    .startPulse(startPulse),
    .endPulse(endPulse),
    .byteIdx_q(byteIdx),
    .rxStrobe_q(rxStrobe),
    .rxIdx_q(rxIdx),
    .rxByte_q(rxByte),
    .misoOut(misoOut),
    .misoOe(misoOe)
  );

  // ----------------------------------------------------------------
  // received control bytes, staged and applied
  // ----------------------------------------------------------------
  reg [7:0] rxMode_q; // mode byte of this frame
  reg [7:0] rxRate_q; // rate byte of this frame
  reg gotMode_q; // mode byte arrived this frame
  reg gotRate_q; // rate byte arrived this frame
  reg [7:0] stagedMode_q; // written, not yet in force
  reg [7:0] activeMode_q; // mode in force
  reg [7:0] rate_q; // rate value in force

  // first byte is mode, second is rate
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxMode_q <= `PSR_MODE_RESET;
      rxRate_q <= `PSR_RATE_RESET;
      gotMode_q <= 1'b0;
      gotRate_q <= 1'b0;
    end
    else if (startPulse)
    begin
      gotMode_q <= 1'b0;
      gotRate_q <= 1'b0;
    end
    else if (rxStrobe)
    begin
      if (rxIdx == 5'h00)
      begin
        rxMode_q <= rxByte;
        gotMode_q <= 1'b1;
      end
      else if (rxIdx == 5'h01)
      begin
        rxRate_q <= rxByte;
        gotRate_q <= 1'b1;
      end
    end
  end

  // staging: a frame's mode takes hold when the next frame opens,
  // after that frame's data has already been frozen
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stagedMode_q <= `PSR_MODE_RESET;
      activeMode_q <= `PSR_MODE_RESET;
      rate_q <= `PSR_RATE_RESET;
    end
    else
    begin
      if (endPulse && gotMode_q)
        stagedMode_q <= rxMode_q;
      // rate needs no latency; only complete bytes count
      if (endPulse && gotRate_q)
        rate_q <= rxRate_q;
      if (startPulse)
        activeMode_q <= stagedMode_q;
    end
  end

  // range and filter fields drive the front end
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rangeSel_q <= 2'b11;
      filterSel_q <= 3'b100;
      noiseSupEn_q <= 1'b1;
    end
    else
    begin
      rangeSel_q <= activeMode_q[`PSR_MODE_RANGE_MSB:`PSR_MODE_RANGE_LSB];
      filterSel_q <= activeMode_q[`PSR_MODE_FILT_MSB:`PSR_MODE_FILT_LSB];
      noiseSupEn_q <= activeMode_q[`PSR_MODE_NOISE_SUP];
    end
  end

  // ----------------------------------------------------------------
  // output shaping: scale, zero, suppression
  // ----------------------------------------------------------------
  reg [15:0] scaled_q; // compensated value at 90 percent span
  reg [15:0] zeroPt_q; // captured zero point
  reg trackMode_q; // tracking chosen at enable edge
  reg [15:0] outPress_q; // pressure ready for the stream
  reg [15:0] outTemp_q; // temperature ready for the stream
  reg [31:0] product; // scaling product
  reg [15:0] shaped; // next output word
  wire azRise; // enable bit rising on promotion
  wire [15:0] dev; // distance from zero point

  assign azRise = startPulse & stagedMode_q[`PSR_MODE_AZ_EN] & ~activeMode_q[`PSR_MODE_AZ_EN];
  assign dev = subSat(scaled_q, zeroPt_q);

  // multiply by 0.9 in fixed point
  always @*
  begin
    product = $signed(rawPressure) * $signed({1'b0, `PSR_SCALE_NUM});
  end

  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scaled_q <= 16'h0000;
      outTemp_q <= 16'h0000;
    end
    else if (rawValid)
    begin
      scaled_q <= product[30:15];
      // temperature passes as 8.8 fixed point
      outTemp_q <= tempIn;
    end
  end

  // zero point capture and tracking
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      zeroPt_q <= 16'h0000;
      trackMode_q <= 1'b0;
    end
    else if (azRise)
    begin
      zeroPt_q <= scaled_q;
      trackMode_q <= stagedMode_q[`PSR_MODE_AZ_TRACK];
    end
    else if (activeMode_q[`PSR_MODE_AZ_EN] && trackMode_q && mag16(dev) <= `PSR_NOISE_FLOOR)
      // follow zero inside noise floor only
      zeroPt_q <= scaled_q;
  end

  // combine zero offset and suppression
  always @*
  begin
    shaped = scaled_q;
    if (activeMode_q[`PSR_MODE_AZ_EN])
      shaped = dev;
    if (activeMode_q[`PSR_MODE_NOISE_SUP] && mag16(shaped) <= `PSR_NOISE_FLOOR)
      shaped = 16'h0000;
  end

  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      outPress_q <= 16'h0000;
    else
      outPress_q <= shaped;
  end

  // ----------------------------------------------------------------
  // stream snapshot and byte selection
  // ----------------------------------------------------------------
  reg [15:0] snapPress_q; // pressure frozen for this frame
  reg [15:0] snapTemp_q; // temperature frozen for this frame

  // one snapshot serves the whole frame
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      snapPress_q <= 16'h0000;
      snapTemp_q <= 16'h0000;
    end
    else if (startPulse)
    begin
      snapPress_q <= outPress_q;
      snapTemp_q <= outTemp_q;
    end
  end

  // byte order of the extended stream
  always @*
  begin
    txByte = `PSR_UNDEF_BYTE;
    if (byteIdx == `PSR_IDX_PRESS_HI)
      txByte = snapPress_q[15:8];
    else if (byteIdx == `PSR_IDX_PRESS_LO)
      txByte = snapPress_q[7:0];
    else if (byteIdx == `PSR_IDX_TEMP_HI)
      txByte = snapTemp_q[15:8];
    else if (byteIdx == `PSR_IDX_TEMP_LO)
      txByte = snapTemp_q[7:0];
    else if (byteIdx < `PSR_IDX_SERIAL_0)
      txByte = MODEL_TEXT[8 * (5 - (byteIdx - `PSR_IDX_MODEL_0)) +: 8];
    else if (byteIdx < `PSR_IDX_BUILD_0)
      txByte = SERIAL_NUM[8 * (3 - (byteIdx - `PSR_IDX_SERIAL_0)) +: 8];
    else if (byteIdx < `PSR_STREAM_LEN)
      txByte = BUILD_TEXT[8 * (5 - (byteIdx - `PSR_IDX_BUILD_0)) +: 8];
    // past the stream the filler byte goes out
  end

  // ----------------------------------------------------------------
  // data-ready pacing
  // ----------------------------------------------------------------
  // a short frame only reads what it clocked; clearing is per frame
  psr_rate_gen uRate (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .updateTick(rawValid),
    .rateValue(rate_q),
    .filterSel(activeMode_q[`PSR_MODE_FILT_MSB:`PSR_MODE_FILT_LSB]),
    .pressRead(startPulse),
    .data_ready_flag(data_ready_flag)
  );

endmodule // psr_readout

//--- test/psr_readout_assertions.sv
// concurrent checks on the pressure readout ports
module psr_readout_assertions (
  input wire clk_sys,
  input wire rst_b,
  input wire rawValid,
  input wire port_select_low,
  input wire misoOe,
  input wire data_ready_flag,
  input wire [1:0] rangeSel_q,
  input wire [2:0] filterSel_q,
  input wire noiseSupEn_q,
  input wire spiMode_q,
  input wire ifaceReady_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_reset_modes:
    assert property (!ifaceReady_q |-> {noiseSupEn_q, filterSel_q, rangeSel_q} == 6'h33) else $error("mode moved");
  a_link_quiet:
    assert property (!ifaceReady_q |-> !misoOe) else $error("output on before strap");
  a_strap_stable:
    assert property ($past(ifaceReady_q) |-> ifaceReady_q && $stable(spiMode_q)) else $error("strap changed");
  a_oe_idle:
    assert property (port_select_low [*6] |-> !misoOe) else $error("output on while deselected");
  a_oe_open:
    assert property ((ifaceReady_q && spiMode_q && !port_select_low) [*6] |-> misoOe) else $error("output off in frame");
  a_mode_change:
    assert property ($changed({noiseSupEn_q, filterSel_q, rangeSel_q}) |-> !port_select_low && !$past(port_select_low))
      else $error("mode changed outside frame start");
  a_ready_clear:
    assert property ($fell(data_ready_flag) |-> !$past(port_select_low, 2)) else $error("ready fell without read");
  a_ready_rise:
    assert property ($rose(data_ready_flag) |-> $past(rawValid)) else $error("ready rose without tick");
endmodule // psr_readout_assertions

bind psr_readout psr_readout_assertions psr_readout_assertions_i (.clk_sys(clk_sys), .rst_b(rst_b),
  .rawValid(rawValid), .port_select_low(port_select_low), .misoOe(misoOe), .data_ready_flag(data_ready_flag),
  .rangeSel_q(rangeSel_q), .filterSel_q(filterSel_q), .noiseSupEn_q(noiseSupEn_q), .spiMode_q(spiMode_q),
  .ifaceReady_q(ifaceReady_q));

//--- test/psr_host_model.sv
// host master model for the four-wire link
module psr_host_model (
  input wire clk_sys,
  output logic port_select_low,
  output logic sclkPin,
  output logic mosiPin,
  input wire misoOut
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock idles low outside frames
  initial
  begin
    port_select_low = 1'b1;
    sclkPin = 1'b0;
    mosiPin = 1'b0;
  end
  // mode, rate, filler; msb first in one select
  task automatic xfer(input logic [7:0] m, input logic [7:0] r, input int n, output logic [159:0] got);
    logic [7:0] tx;
    got = '0;
    @(negedge clk_sys);
    port_select_low = 1'b0;
    #1000;
    // keep clocking while more bytes are wanted
    for (int i = 0; i < n * 8; i++)
    begin
      tx = (i < 8) ? m : (i < 16) ? r : 8'hA5;
      mosiPin = tx[7 - i % 8];
      #400 sclkPin = 1'b1;
      got = {got[158:0], misoOut};
      #400 sclkPin = 1'b0;
    end
    #400 port_select_low = 1'b1;
    // released line must not show a stale bit
    mosiPin = ~mosiPin;
    #1000;
  endtask
endmodule // psr_host_model

//--- test/tb_top.sv
// self-checking bench of the pressure readout block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [47:0] MODEL = 48'h4D4F_4445_4C00; // arbitrary value
  localparam logic [31:0] SERIAL = 32'hA1B2_C3D4; // arbitrary value
  localparam logic [47:0] BUILD = 48'h4255_494C_4400; // arbitrary value
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] rawPressure = 16'h1000;
  logic rawValid = 1'b0;
  logic [15:0] tempIn = 16'h1880;
  wire port_select_low, sclkPin, mosiPin, misoOut, misoOe, data_ready_flag, noiseSupEn_q, spiMode_q, ifaceReady_q;
  wire [1:0] rangeSel_q;
  wire [2:0] filterSel_q;
  logic [159:0] got;
  int n_mismatch = 0;
  int check_count = 0;
  int k;
  always #50 clk_sys = ~clk_sys;
  psr_readout #(.MODEL_TEXT(MODEL), .SERIAL_NUM(SERIAL), .BUILD_TEXT(BUILD)) psr_readout_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .rawPressure(rawPressure), .rawValid(rawValid), .tempIn(tempIn),
    .port_select_low(port_select_low), .sclkPin(sclkPin), .mosiPin(mosiPin), .misoOut(misoOut), .misoOe(misoOe),
    .data_ready_flag(data_ready_flag), .rangeSel_q(rangeSel_q), .filterSel_q(filterSel_q),
    .noiseSupEn_q(noiseSupEn_q), .spiMode_q(spiMode_q), .ifaceReady_q(ifaceReady_q));
  psr_host_model psr_host_model_i (.clk_sys(clk_sys), .port_select_low(port_select_low), .sclkPin(sclkPin),
    .mosiPin(mosiPin), .misoOut(misoOut));
  task automatic check(input string what, input logic [159:0] seen, input logic [159:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one internal update pulse
  task automatic tick;
    @(negedge clk_sys) rawValid = 1'b1;
    @(negedge clk_sys) rawValid = 1'b0;
  endtask
  // watchdog: the run needs well under a millisecond
  initial
  begin
    #3000000;
    n_mismatch++;
    complete_run;
  end
  initial
  begin
    repeat (5) @(negedge clk_sys);
    check("modes", {noiseSupEn_q, filterSel_q, rangeSel_q}, 6'h33);
    rst_b = 1'b1;
    repeat (120) @(negedge clk_sys); // no frame during start-up
    check("strap", {spiMode_q, ifaceReady_q}, 2'h3);
    tick;
    @(negedge clk_sys);
    check("ready", data_ready_flag, 1'b1);
    // full stream, filler bytes must not reach the modes
    psr_host_model_i.xfer(8'h93, 8'h00, 20, got);
    check("press", got[159:144], 16'h0E66);
    check("temp", got[143:128], 16'h1880);
    check("ident", got[127:0], {MODEL, SERIAL, BUILD});
    check("cleared", data_ready_flag, 1'b0);
    psr_host_model_i.xfer(8'h85, 8'h03, 2, got);
    check("old modes", {noiseSupEn_q, filterSel_q, rangeSel_q}, 6'h33);
    psr_host_model_i.xfer(8'h85, 8'h03, 2, got);
    check("new modes", {noiseSupEn_q, filterSel_q, rangeSel_q}, 6'h25);
    // divide by three once the rate is in force
    for (k = 0; k < 8 && data_ready_flag !== 1'b1; k++) tick;
    psr_host_model_i.xfer(8'h85, 8'h03, 2, got);
    for (k = 0; k < 8 && data_ready_flag !== 1'b1; k++) tick;
    check("rate", k, 3);
    // zero capture then release of the offset
    psr_host_model_i.xfer(8'hA5, 8'h03, 2, got);
    psr_host_model_i.xfer(8'hA5, 8'h03, 2, got);
    psr_host_model_i.xfer(8'h85, 8'h03, 2, got);
    check("zeroed", got[15:0], 16'h0000);
    psr_host_model_i.xfer(8'h85, 8'h03, 2, got);
    psr_host_model_i.xfer(8'h85, 8'h03, 2, got);
    check("unzeroed", got[15:0], 16'h0E66);
    // tracking chosen at the enable edge, no suppression
    psr_host_model_i.xfer(8'h65, 8'h03, 2, got);
    psr_host_model_i.xfer(8'h65, 8'h03, 2, got);
    // small step inside the noise floor is followed
    rawPressure = 16'h1008;
    tick;
    psr_host_model_i.xfer(8'h65, 8'h03, 2, got);
    check("tracked", got[15:0], 16'h0000);
    // excursion suspends tracking: offset from the held zero
    rawPressure = 16'h2000;
    tick;
    psr_host_model_i.xfer(8'h65, 8'h03, 2, got);
    check("excursion", got[15:0], 16'h0E5F);
    complete_run;
  end
endmodule // tb_top
